// *** logic/supply_seq_map.vh ***
// Constants for the supply power sequencer
`ifndef SUPPLY_SEQ_MAP_VH
`define SUPPLY_SEQ_MAP_VH
`define MCLK_PERIOD_NS 40
`define SLOW_CLK_PERIOD_NS 30518
`define FORCE_WAKE_PIN_DEBOUNCE_TICKS 30
`define LOSS_MIN_TICKS 2
`define LEVEL_W 4
`define LEVEL_RESET 4'hF
`define CMD_SHUTDOWN 0
`define CMD_SHUTDOWN_EOF 1
`define CMD_REG_OFF 2
`define MODE_LOSS_EN 0
`define MODE_DEEP 1
`define MODE_RETAIN 2
`define MODE_CLK_PWR 3
`define MODE_LEVEL_LSB 4
`endif

// *** logic/slow_tick.v ***
// Divider giving a one-cycle slow clock enable
`timescale 1ns/1ns
`default_nettype none
module slow_tick #(
	parameter DIV = 762
) (
	input wire mclk_in,
	input wire rst_n_in,
	output reg tick_out
);
	reg [15:0] cnt_r;
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 16'h0000;
			tick_out <= 1'b0;
		end else if (cnt_r == DIV[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			tick_out <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule // slow_tick
`default_nettype wire

// *** logic/wr_resync.v ***
// Two-stage write resynchronizer stepped by the slow tick
`timescale 1ns/1ns
`default_nettype none
module wr_resync #(
	parameter W = 1
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire tick_in,
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [W-1:0] meta_r;
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= {W{1'b0}};
			q_out <= {W{1'b0}};
		end else if (tick_in) begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // wr_resync
`default_nettype wire

// *** logic/supply_power_sequencer.v ***
// Supply power sequencer: core reset, shutdown, regulator, SRAM and clock-domain power
`timescale 1ns/1ns
`default_nettype none
`include "supply_seq_map.vh"
module supply_power_sequencer #(
	parameter LEVEL_W = `LEVEL_W,
	parameter FORCE_WAKE_PIN_TICKS = `FORCE_WAKE_PIN_DEBOUNCE_TICKS
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire force_wake_pin_n_in,
	input wire regulator_good_in,
	input wire display_frame_done_in,
	input wire charge_pump_on_in,
	input wire wake_request_in,
	input wire shutdown_cmd_in,
	input wire shutdown_at_frame_end_cmd_in,
	input wire regulator_off_cmd_in,
	input wire mode_wr_in,
	input wire reg_loss_reset_enable_in,
	input wire regulator_low_leak_in,
	input wire sram_retain_enable_in,
	input wire clock_domain_power_enable_in,
	input wire [LEVEL_W-1:0] regulator_level_sel_in,
	input wire status_read_in,
	output reg supply_hold_out,
	output reg core_reset_n_out,
	output reg regulator_on_out,
	output reg regulator_deep_out,
	output reg [LEVEL_W-1:0] regulator_level_out,
	output reg display_reset_n_out,
	output reg pump_off_out,
	output reg flash_reset_n_out,
	output reg flash_power_out,
	output reg sram_power_out,
	output reg clock_domain_switch_out,
	output reg clock_domain_reset_n_out,
	output reg clock_domain_power_flag_out,
	output reg reg_loss_reset_flag_out,
	output reg backup_mode_out,
	output reg clock_domain_power_enable_out
);
	localparam DIV = `SLOW_CLK_PERIOD_NS / `MCLK_PERIOD_NS;
	localparam MW = LEVEL_W + 4;

	localparam ST_DEB = 13'h0001;
	localparam ST_VRWAIT = 13'h0002;
	localparam ST_RUN = 13'h0004;
	localparam ST_LOSS = 13'h0008;
	localparam ST_VOFF = 13'h0010;
	localparam ST_BACKUP = 13'h0020;
	localparam ST_SD_REG = 13'h0040;
	localparam ST_SD_EOF = 13'h0080;
	localparam ST_SD_LCD = 13'h0100;
	localparam ST_SD_FLASH = 13'h0200;
	localparam ST_SD_SRAM = 13'h0400;
	localparam ST_SD_RTC = 13'h0800;
	localparam ST_SD_OFF = 13'h1000;

	wire tick;
	wire [2:0] cmd_sync;
	wire [MW-1:0] mode_sync;
	reg [2:0] cmd_pend_r;
	reg [2:0] cmd_seen_r;
	reg [MW-1:0] mode_r;
	reg [12:0] state_r;
	reg [7:0] cnt_r;
	reg low_seen_r;
	reg eof_mode_r;
	reg clk_busy_r;

	wire [2:0] cmd_fire = cmd_sync & ~cmd_seen_r;
	wire loss_en = mode_sync[`MODE_LOSS_EN];
	wire deep = mode_sync[`MODE_DEEP];
	wire retain = mode_sync[`MODE_RETAIN];
	wire clk_pwr = mode_sync[`MODE_CLK_PWR];

	slow_tick #(
		.DIV(DIV)
	) u_tick (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.tick_out(tick)
	);

	// Commands and mode bits pass two slow ticks before taking effect
	wr_resync #(
		.W(3)
	) u_cmd_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.d_in(cmd_pend_r),
		.q_out(cmd_sync)
	);

	wr_resync #(
		.W(MW)
	) u_mode_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.d_in(mode_r),
		.q_out(mode_sync)
	);

	// Software side: pending commands and written mode
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_pend_r <= 3'h0;
			cmd_seen_r <= 3'h0;
			mode_r <= {`LEVEL_RESET, 4'h0};
			clock_domain_power_enable_out <= 1'b0;
		end else begin
			// A new write wins over the clear of an old pending command
			cmd_pend_r <= (cmd_pend_r & ~cmd_sync) |
				{regulator_off_cmd_in, shutdown_at_frame_end_cmd_in, shutdown_cmd_in};
			// Seen copy steps with the tick so each command fires on exactly one tick
			if (tick)
				cmd_seen_r <= cmd_sync;
			if (mode_wr_in) begin
				mode_r <= {regulator_level_sel_in, clock_domain_power_enable_in,
					sram_retain_enable_in, regulator_low_leak_in, reg_loss_reset_enable_in};
				clock_domain_power_enable_out <= clock_domain_power_enable_in;
			end
		end
	end

	// Slow-tick sequencer
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_DEB;
			cnt_r <= 8'h00;
			low_seen_r <= 1'b0;
			eof_mode_r <= 1'b0;
			clk_busy_r <= 1'b0;
			supply_hold_out <= 1'b0;
			core_reset_n_out <= 1'b0;
			regulator_on_out <= 1'b0;
			regulator_deep_out <= 1'b0;
			regulator_level_out <= `LEVEL_RESET;
			display_reset_n_out <= 1'b1;
			pump_off_out <= 1'b0;
			flash_reset_n_out <= 1'b0;
			flash_power_out <= 1'b0;
			sram_power_out <= 1'b0;
			clock_domain_switch_out <= 1'b0;
			clock_domain_reset_n_out <= 1'b0;
			clock_domain_power_flag_out <= 1'b0;
			reg_loss_reset_flag_out <= 1'b0;
			backup_mode_out <= 1'b0;
		end else begin
			if (status_read_in)
				reg_loss_reset_flag_out <= 1'b0;
			if (tick) begin
				regulator_level_out <= mode_sync[MW-1:4];
				regulator_deep_out <= deep;
				case (state_r)
				ST_DEB: begin
					// Supply closes only while the force-wake pin stays low
					if (force_wake_pin_n_in) begin
						cnt_r <= 8'h00;
					end else if (cnt_r == FORCE_WAKE_PIN_TICKS[7:0] - 8'h01) begin
						cnt_r <= 8'h00;
						supply_hold_out <= 1'b1;
						regulator_on_out <= 1'b1;
						flash_power_out <= 1'b1;
						sram_power_out <= 1'b1;
						state_r <= ST_VRWAIT;
					end else begin
						cnt_r <= cnt_r + 8'h01;
					end
				end
				ST_VRWAIT: begin
					// Good must be seen on one tick and still be good on the next
					if (!regulator_good_in) begin
						cnt_r <= 8'h00;
					end else if (cnt_r != 8'h00) begin
						cnt_r <= 8'h00;
						core_reset_n_out <= 1'b1;
						flash_reset_n_out <= 1'b1;
						backup_mode_out <= 1'b0;
						low_seen_r <= 1'b0;
						state_r <= ST_RUN;
					end else begin
						cnt_r <= 8'h01;
					end
				end
				ST_RUN: begin
					low_seen_r <= !regulator_good_in;
					if (cmd_fire[`CMD_SHUTDOWN] || cmd_fire[`CMD_SHUTDOWN_EOF]) begin
						core_reset_n_out <= 1'b0;
						eof_mode_r <= cmd_fire[`CMD_SHUTDOWN_EOF] &
							!cmd_fire[`CMD_SHUTDOWN];
						state_r <= ST_SD_REG;
					end else if (cmd_fire[`CMD_REG_OFF]) begin
						core_reset_n_out <= 1'b0;
						state_r <= ST_VOFF;
					end else if (loss_en && !deep && low_seen_r && !regulator_good_in) begin
						core_reset_n_out <= 1'b0;
						reg_loss_reset_flag_out <= 1'b1;
						cnt_r <= 8'h01;
						state_r <= ST_LOSS;
					end
				end
				ST_LOSS: begin
					if (cnt_r < `LOSS_MIN_TICKS)
						cnt_r <= cnt_r + 8'h01;
					else if (regulator_good_in) begin
						cnt_r <= 8'h00;
						core_reset_n_out <= 1'b1;
						low_seen_r <= 1'b0;
						state_r <= ST_RUN;
					end
				end
				ST_VOFF: begin
					// Core held one tick in reset before its power goes
					regulator_on_out <= 1'b0;
					flash_power_out <= 1'b0;
					flash_reset_n_out <= 1'b0;
					sram_power_out <= retain;
					backup_mode_out <= 1'b1;
					state_r <= ST_BACKUP;
				end
				ST_BACKUP: begin
					if (wake_request_in) begin
						regulator_on_out <= 1'b1;
						flash_power_out <= 1'b1;
						sram_power_out <= 1'b1;
						cnt_r <= 8'h00;
						state_r <= ST_VRWAIT;
					end
				end
				ST_SD_REG: begin
					regulator_on_out <= 1'b0;
					if (!charge_pump_on_in)
						state_r <= ST_SD_FLASH;
					else if (eof_mode_r)
						state_r <= ST_SD_EOF;
					else
						state_r <= ST_SD_LCD;
				end
				ST_SD_EOF: begin
					if (display_frame_done_in)
						state_r <= ST_SD_LCD;
				end
				ST_SD_LCD: begin
					if (display_reset_n_out)
						display_reset_n_out <= 1'b0;
					else begin
						pump_off_out <= 1'b1;
						state_r <= ST_SD_FLASH;
					end
				end
				ST_SD_FLASH: begin
					if (flash_reset_n_out)
						flash_reset_n_out <= 1'b0;
					else begin
						flash_power_out <= 1'b0;
						state_r <= ST_SD_SRAM;
					end
				end
				ST_SD_SRAM: begin
					sram_power_out <= 1'b0;
					state_r <= ST_SD_RTC;
				end
				ST_SD_RTC: begin
					if (clock_domain_reset_n_out)
						clock_domain_reset_n_out <= 1'b0;
					else begin
						clock_domain_switch_out <= 1'b0;
						clock_domain_power_flag_out <= 1'b0;
						state_r <= ST_SD_OFF;
					end
				end
				ST_SD_OFF: begin
					supply_hold_out <= 1'b0;
				end
				default: begin
					state_r <= ST_DEB;
				end
				endcase
				// Clock-domain power, idle while a shutdown owns it
				if (state_r < ST_SD_REG || state_r == ST_BACKUP) begin
					if (clk_busy_r) begin
						// Direction of the running sequence follows the written bit
						if (clk_pwr) begin
							clk_busy_r <= 1'b0;
							clock_domain_reset_n_out <= 1'b1;
							clock_domain_power_flag_out <= 1'b1;
						end else if (clock_domain_switch_out) begin
							clock_domain_switch_out <= 1'b0;
						end else begin
							clk_busy_r <= 1'b0;
							clock_domain_power_flag_out <= 1'b0;
						end
					end else if (clk_pwr && !clock_domain_switch_out) begin
						clock_domain_switch_out <= 1'b1;
						clk_busy_r <= 1'b1;
					end else if (!clk_pwr && clock_domain_reset_n_out) begin
						clock_domain_reset_n_out <= 1'b0;
						clk_busy_r <= 1'b1;
					end else if (!clk_pwr && clock_domain_switch_out) begin
						clock_domain_switch_out <= 1'b0;
						clk_busy_r <= 1'b1;
					end
				end
			end
		end
	end
endmodule // supply_power_sequencer
`default_nettype wire

// *** verif/supply_partner.sv ***
// Regulator model: good level follows the enable after a settling delay
`timescale 1ns/1ns
`default_nettype none
module supply_partner (
	input wire logic mclk_in,
	input wire logic regulator_on_in,
	input wire logic drop_in,
	output wire logic regulator_good_out
);
	logic [7:0] settle_r = 8'h00;
	// Good stays low while off or while a loss is commanded
	always @(posedge mclk_in) begin
		if (!regulator_on_in || drop_in) settle_r <= 8'h00;
		else if (settle_r != 8'hff) settle_r <= settle_r + 8'h01;
	end
	assign regulator_good_out = (settle_r == 8'hff);
endmodule // supply_partner
`default_nettype wire

// *** verif/supply_power_sequencer_assertions.sv ***
// Port relations of the supply power sequencer
`timescale 1ns/1ns
`default_nettype none
module supply_power_sequencer_assertions (
	input wire mclk_in,
	input wire rst_n_in,
	input wire regulator_good_in,
	input wire supply_hold_out,
	input wire core_reset_n_out,
	input wire regulator_on_out,
	input wire flash_power_out,
	input wire sram_power_out,
	input wire clock_domain_switch_out,
	input wire clock_domain_reset_n_out,
	input wire clock_domain_power_flag_out,
	input wire reg_loss_reset_flag_out,
	input wire backup_mode_out,
	input wire clock_domain_power_enable_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	property p_rst_dom;
		$rose(rst_n_in) |-> !clock_domain_switch_out && !clock_domain_power_enable_out;
	endproperty
	a_rst_dom: assert property (p_rst_dom) else $error("clock domain on after reset");
	property p_dom_on; $rose(clock_domain_switch_out) |-> !clock_domain_reset_n_out [*8]; endproperty
	a_dom_on: assert property (p_dom_on) else $error("domain reset released early");
	property p_dom_off;
		$fell(clock_domain_switch_out) |-> !clock_domain_reset_n_out && !$past(clock_domain_reset_n_out);
	endproperty
	a_dom_off: assert property (p_dom_off) else $error("switch opened before reset");
	property p_flag;
		$rose(clock_domain_power_flag_out) |-> clock_domain_switch_out && clock_domain_reset_n_out;
	endproperty
	a_flag: assert property (p_flag) else $error("power flag before switch-on done");
	property p_off;
		$fell(supply_hold_out) |-> !(core_reset_n_out || regulator_on_out || sram_power_out
			|| flash_power_out || clock_domain_switch_out);
	endproperty
	a_off: assert property (p_off) else $error("hold dropped with a supply still on");
	property p_reg_off; $fell(regulator_on_out) |-> !core_reset_n_out && !$past(core_reset_n_out, 8); endproperty
	a_reg_off: assert property (p_reg_off) else $error("regulator off without core reset");
	property p_sram; regulator_on_out |-> sram_power_out; endproperty
	a_sram: assert property (p_sram) else $error("sram off with core on");
	property p_loss_flag; $rose(reg_loss_reset_flag_out) |-> !core_reset_n_out; endproperty
	a_loss_flag: assert property (p_loss_flag) else $error("loss flag without core reset");
	property p_release;
		$rose(core_reset_n_out) |-> regulator_good_in && $past(regulator_good_in, 8);
	endproperty
	a_release: assert property (p_release) else $error("core released without good");
	property p_min_rst; $fell(core_reset_n_out) |-> !core_reset_n_out [*8]; endproperty
	a_min_rst: assert property (p_min_rst) else $error("core reset too short");
	c_off: cover property ($fell(supply_hold_out));
	c_loss: cover property ($rose(reg_loss_reset_flag_out));
	c_backup: cover property ($rose(backup_mode_out));
endmodule // supply_power_sequencer_assertions
`default_nettype wire

// *** verif/test_supply_power_sequencer.sv ***
// Self-checking bench for the supply power sequencer
`timescale 1ns/1ns
`default_nettype none
module test_supply_power_sequencer;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic drop = 1'b0;
	logic eof = 1'b0;
	logic pump = 1'b0;
	logic wk = 1'b0;
	logic sr = 1'b0;
	logic mw = 1'b0;
	logic [2:0] cmd = 3'h0;
	logic [7:0] mf = 8'h00;
	logic [15:0] rnd = 16'h0fa9;
	logic [18:0] q[$];
	logic [18:0] mk;
	logic [18:0] ev;
	wire good;
	wire [18:0] o;
	event chk;
	int num_errors = 0;
	int cmp_count = 0;
	supply_power_sequencer #(.FORCE_WAKE_PIN_TICKS(2)) supply_power_sequencer_inst (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .force_wake_pin_n_in(1'b0), .regulator_good_in(good),
		.display_frame_done_in(eof), .charge_pump_on_in(pump), .wake_request_in(wk),
		.shutdown_cmd_in(cmd[0]), .shutdown_at_frame_end_cmd_in(cmd[1]),
		.regulator_off_cmd_in(cmd[2]), .mode_wr_in(mw), .reg_loss_reset_enable_in(mf[0]),
		.regulator_low_leak_in(mf[1]), .sram_retain_enable_in(mf[2]),
		.clock_domain_power_enable_in(mf[3]), .regulator_level_sel_in(mf[7:4]),
		.status_read_in(sr), .supply_hold_out(o[0]), .core_reset_n_out(o[1]),
		.regulator_on_out(o[2]), .regulator_deep_out(o[3]), .display_reset_n_out(o[4]),
		.pump_off_out(o[5]), .flash_reset_n_out(o[6]), .flash_power_out(o[7]),
		.sram_power_out(o[8]), .clock_domain_switch_out(o[9]), .clock_domain_reset_n_out(o[10]),
		.clock_domain_power_flag_out(o[11]), .reg_loss_reset_flag_out(o[12]),
		.backup_mode_out(o[13]), .clock_domain_power_enable_out(o[14]),
		.regulator_level_out(o[18:15]));
	supply_partner supply_partner_inst (.mclk_in(mclk_in), .regulator_on_in(o[2]),
		.drop_in(drop), .regulator_good_out(good));
	initial forever #20 mclk_in = ~mclk_in;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task check(input logic [18:0] seen, input logic [18:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] outputs exp=%h seen=%h", exp, seen);
		end
	endtask
	task expect_out(input logic [18:0] m, input logic [18:0] v);
		q.push_back(m);
		q.push_back(v);
		->chk;
		#1;
	endtask
	always @(chk) begin
		mk = q.pop_front();
		ev = q.pop_front();
		check(o & mk, ev);
	end
	task wait_out(input logic [18:0] m, input logic [18:0] v);
		int i;
		for (i = 0; i < 30000 && (o & m) !== v; i++) @(posedge mclk_in);
		if (i >= 30000) begin
			num_errors++;
			$display("[ERR] wait_out exp=%h seen=%h", v, o & m);
		end
		@(negedge mclk_in);
	endtask
	task ticks(input int n);
		repeat (n * 762) @(negedge mclk_in);
	endtask
	task mode(input logic [7:0] f);
		@(negedge mclk_in) mf = f;
		mw = 1'b1;
		@(negedge mclk_in) mw = 1'b0;
	endtask
	task pulse(input logic [2:0] c);
		@(negedge mclk_in) cmd = c;
		@(negedge mclk_in) cmd = 3'h0;
	endtask
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#3900000;
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (3) @(negedge mclk_in);
		expect_out(19'h7_ffff, 19'h7_8010);
		rst_n_in = 1'b1;
		wait_out(19'h2, 19'h2);
		expect_out(19'h1c7, 19'h1c7);
		rnd = lfsr(rnd);
		mode({rnd[3:0], 4'b1001});
		// Software waits for the flag before touching the bit again
		wait_out(19'h800, 19'h800);
		expect_out(19'h7_ce08, {rnd[3:0], 15'h4e00});
		mode({rnd[3:0], 4'b1001});
		ticks(5);
		expect_out(19'h7_ce08, {rnd[3:0], 15'h4e00});
		drop = 1'b1;
		wait_out(19'h2, 19'h0);
		expect_out(19'h1002, 19'h1000);
		drop = 1'b0;
		wait_out(19'h2, 19'h2);
		sr = 1'b1;
		@(negedge mclk_in) sr = 1'b0;
		@(negedge mclk_in);
		expect_out(19'h1002, 19'h2);
		mode({rnd[3:0], 4'b1011});
		ticks(4);
		drop = 1'b1;
		ticks(4);
		expect_out(19'ha, 19'ha);
		drop = 1'b0;
		ticks(2);
		mode({rnd[3:0], 4'b0001});
		wait_out(19'he00, 19'h0);
		expect_out(19'h4e08, 19'h0);
		for (int r = 0; r < 2; r++) begin
			mode({rnd[3:0], 1'b0, r[0], 2'b01});
			ticks(4);
			pulse(3'b100);
			wait_out(19'h2000, 19'h2000);
			expect_out(19'h2106, r[0] ? 19'h2100 : 19'h2000);
			wk = 1'b1;
			wait_out(19'h2002, 19'h2);
			wk = 1'b0;
			expect_out(19'h106, 19'h106);
		end
		for (int c = 0; c < 2; c++) begin
			mode({rnd[3:0], 4'b1000});
			wait_out(19'h800, 19'h800);
			pump = 1'b1;
			eof = 1'b0;
			pulse(c ? 3'b001 : 3'b010);
			wait_out(19'h4, 19'h0);
			ticks(3);
			expect_out(19'h10, c ? 19'h0 : 19'h10);
			eof = 1'b1;
			wait_out(19'h1, 19'h0);
			expect_out(19'hff7, 19'h20);
			rst_n_in = 1'b0;
			repeat (3) @(negedge mclk_in);
			rst_n_in = 1'b1;
			wait_out(19'h2, 19'h2);
		end
		end_sim;
	end
endmodule // test_supply_power_sequencer
bind supply_power_sequencer supply_power_sequencer_assertions supply_power_sequencer_assertions_inst (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .regulator_good_in(regulator_good_in),
	.supply_hold_out(supply_hold_out), .core_reset_n_out(core_reset_n_out),
	.regulator_on_out(regulator_on_out), .flash_power_out(flash_power_out),
	.sram_power_out(sram_power_out), .clock_domain_switch_out(clock_domain_switch_out),
	.clock_domain_reset_n_out(clock_domain_reset_n_out),
	.clock_domain_power_flag_out(clock_domain_power_flag_out),
	.reg_loss_reset_flag_out(reg_loss_reset_flag_out), .backup_mode_out(backup_mode_out),
	.clock_domain_power_enable_out(clock_domain_power_enable_out));
`default_nettype wire
